// ===== rtl/pcr_cfg.svh
// offsets, field positions and reset values of the configuration header registers
`ifndef PCR_CFG_SVH
`define PCR_CFG_SVH

// byte offsets in configuration space
`define PCR_OFS_CACHE_LINE 8'h0C
`define PCR_OFS_LATENCY 8'h0D
`define PCR_OFS_BAR_FIRST 8'h10
`define PCR_OFS_CARD_INFO 8'h28
`define PCR_OFS_SUBSYS 8'h2C
`define PCR_OFS_CAP_PTR 8'h34
`define PCR_OFS_INT_LINE 8'h3C
`define PCR_OFS_INT_PIN 8'h3D
`define PCR_OFS_MAX_LAT 8'h3E
`define PCR_OFS_MIN_GNT 8'h3F

// spacing of consecutive window base registers
`define PCR_DWORD_BYTES 8'h04

// reset values
`define PCR_RST_CACHE_LINE 8'h00
`define PCR_RST_LATENCY 8'h00
`define PCR_RST_INT_LINE 8'h00

// interrupt pin encodings
`define PCR_INT_PIN_A 8'h01
`define PCR_INT_PIN_NONE 8'h00

// window base register fields
`define PCR_BAR_SPACE_BIT 0
`define PCR_BAR_RSVD_BIT 1
`define PCR_BAR_ADDR_LSB 2
`define PCR_BAR_MSB 31
`define PCR_MAX_BARS 6

// width of one byte lane
`define PCR_LANE_W 8

`endif

// ===== rtl/pcr_pkg.sv
// types shared by the configuration header register files
package pcr_pkg;

  // one configuration access from the PCI target side
  typedef struct packed {
    logic wr;            // write strobe, one cycle
    logic rd;            // read strobe, one cycle
    logic [5:0] dword;   // dword index, byte address bits 7:2
    logic [3:0] be;      // byte enables, active high
    logic [31:0] wdata;  // write data
  } pcr_req_t;

  // answer to a configuration access
  typedef struct packed {
    logic ack;           // one cycle after the request
    logic [31:0] rdata;  // read data, valid with ack
  } pcr_rsp_t;

  // state of one I/O window base register
  typedef struct packed {
    logic [29:0] addr;   // address bits 31:2
  } pcr_bar_state_t;

  // state of the writable header registers
  typedef struct packed {
    logic [7:0] cache_line;
    logic [7:0] latency;
    logic [7:0] int_line;
  } pcr_main_state_t;

endpackage

// ===== rtl/pcr_io_bar.sv
// one I/O-mapped window base register
`timescale 1ns/10ps
`default_nettype none
`include "pcr_cfg.svh"

module pcr_io_bar #(
  parameter logic [31:0] BASE_PARAM = 32'hFFFF_FF01  // size mask plus space bit
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic wr_in,          // write aimed at this register
  input wire logic [3:0] be_in,
  input wire logic [31:0] wdata_in,
  output logic [31:0] value_out
);
  import pcr_pkg::*;

  pcr_bar_state_t state_reg;  // registered state
  pcr_bar_state_t state_next; // next state

  // byte-lane write into address bits; the two attribute bits never take data
  always_comb begin
    state_next = state_reg;
    if (wr_in) begin
      for (int b = 0; b < 4; b++) begin
        if (be_in[b]) begin
          for (int k = b * `PCR_LANE_W; k < (b + 1) * `PCR_LANE_W; k++) begin
            if (k >= `PCR_BAR_ADDR_LSB) begin
              state_next.addr[k - `PCR_BAR_ADDR_LSB] = wdata_in[k]; // [R3]
            end
          end
        end
      end
    end
  end

  // initial address comes from the build value
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg.addr <= BASE_PARAM[`PCR_BAR_MSB:`PCR_BAR_ADDR_LSB]; // [R3]
    end else begin
      state_reg <= state_next;
    end
  end

  // space bit from the build value, reserved bit held low
  assign value_out = {state_reg.addr, 1'b0, BASE_PARAM[`PCR_BAR_SPACE_BIT]}; // [R1] [R2] [R4]

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  a_bar_attr_fixed: assert property (wr_in |=> value_out[1:0] == $past(value_out[1:0])) // [R4]
    else $error("io window attribute bits changed on write");
  a_bar_space_bit: assert property (value_out[0] == BASE_PARAM[0] && !value_out[1]) // [R1] [R2]
    else $error("io window space or reserved bit wrong");
  a_bar_addr_write: assert property (wr_in && be_in[0] |=> value_out[7:2] == $past(wdata_in[7:2])) // [R3]
    else $error("io window address byte not stored");

endmodule // pcr_io_bar

`default_nettype wire

// ===== rtl/pcr_read_reg.sv
// registered answer stage of the configuration port
`timescale 1ns/10ps
`default_nettype none

module pcr_read_reg (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic ack_in,         // access taken this cycle
  input wire logic [31:0] data_in, // selected read data
  output pcr_pkg::pcr_rsp_t rsp_out
);
  import pcr_pkg::*;

  pcr_rsp_t state_reg;  // registered answer
  pcr_rsp_t state_next; // next answer

  // data is loaded only on a read or write, else kept
  always_comb begin
    state_next = state_reg;
    state_next.ack = ack_in;
    if (ack_in) begin
      state_next.rdata = data_in;
    end
  end

  // answer flops
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rsp_out = state_reg;

endmodule // pcr_read_reg

`default_nettype wire

// ===== rtl/pcr_header_regs.sv
// configuration header registers of a PCI target, type 0 layout subset
`timescale 1ns/10ps
`default_nettype none
`include "pcr_cfg.svh"

// Behaviour
// (R1) io window bit 0 is build space bit
// (R2) io window bit 1 reads zero always
// (R3) io window bits 31:2 writable, build-initialised
// (R4) size mask build value, attribute bits fixed
// (R5) cache line length at 0x0C, reset zero
// (R6) cache line length driven to local side
// (R7) latency count at 0x0D, optionally writable
// (R8) card info pointer at 0x28, build value
// (R9) subsystem maker code is build value
// (R10) subsystem product code is build value
// (R11) maker low, product high at 0x2C
// (R12) capability start at 0x34, gated by enable
// (R13) min grant in top byte of 0x3C
// (R14) max latency in third byte of 0x3C
// (R15) interrupt routing line is plain storage
// (R16) interrupt pin reads 0x01 when enabled
// (R17) reserved locations: writes dropped, read zero
// (R18) local bus width equals PCI width
// (R19) build-set fields ignore all writes
module pcr_header_regs #(
  parameter int NUM_BARS = 3,                                     // io windows, 1 to 6
  parameter logic [32*`PCR_MAX_BARS-1:0] window_base_params = {`PCR_MAX_BARS{32'hFFFF_FF01}},
  parameter logic [31:0] card_info_ptr_param = 32'h0000_0000,     // card info pointer
  parameter logic [15:0] subsys_maker_param = 16'h0000,           // arbitrary value
  parameter logic [15:0] subsys_product_param = 16'h0000,         // arbitrary value
  parameter logic capability_enable_param = 1'b1,                 // capability pointer valid
  parameter logic [7:0] capability_ptr_param = 8'h40,             // capability list start
  parameter logic [7:0] min_grant_param = 8'h00,                  // burst length, microseconds
  parameter logic [7:0] max_latency_param = 8'h00,                // access rate request
  parameter logic interrupt_enable_param = 1'b1,                  // interrupt A in use
  parameter logic latency_writable_param = 1'b1,                  // latency count writable
  parameter int PCI_BUS_WIDTH = 32                                // 32 or 64
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire pcr_pkg::pcr_req_t req_in,
  output pcr_pkg::pcr_rsp_t rsp_out,
  output logic [7:0] cache_line_out,
  output logic [7:0] latency_count_out,
  output logic [7:0] interrupt_line_out,
  output logic local_wide_bus_out
);
  import pcr_pkg::*;

  // local side matches the PCI side in width
  localparam int LOCAL_BUS_WIDTH = PCI_BUS_WIDTH; // [R18]
  localparam int WIDE_BUS = 64;

  pcr_main_state_t state_reg;  // registered writable registers
  pcr_main_state_t state_next; // next value of them
  logic [31:0] bar_value [NUM_BARS]; // io window register contents
  logic [31:0] read_data;            // selected read word
  logic taken;                       // an access is taken this cycle

  // true when the access addresses the dword holding a byte offset
  // compares dword index only, so every lane of that dword hits
  function automatic logic hits(input pcr_req_t r, input logic [7:0] ofs);
    hits = (r.dword == ofs[7:2]);
  endfunction

  // true when a write enables the byte lane of an offset
  // a write without the lane's enable leaves that byte alone
  function automatic logic wr_hit(input pcr_req_t r, input logic [7:0] ofs);
    wr_hit = r.wr && hits(r, ofs) && r.be[ofs[1:0]];
  endfunction

  // write data byte for the lane of an offset
  // lane number is the low two bits of the byte offset
  function automatic logic [7:0] wr_byte(input pcr_req_t r, input logic [7:0] ofs);
    wr_byte = r.wdata[ofs[1:0] * `PCR_LANE_W +: `PCR_LANE_W];
  endfunction

  // places one byte at the lane of its offset
  // other lanes come out zero so several bytes can be or-ed together
  function automatic logic [31:0] at_lane(input logic [7:0] v, input logic [7:0] ofs);
    at_lane = {24'h00_0000, v} << (ofs[1:0] * `PCR_LANE_W);
  endfunction

  // dword byte offset of window base register i
  // windows sit back to back from the first window offset upward
  function automatic logic [7:0] bar_ofs(input int i);
    bar_ofs = `PCR_OFS_BAR_FIRST + 8'(i) * `PCR_DWORD_BYTES;
  endfunction

  // io window registers, one per configured window
  // each window sees only writes aimed at its own dword
  // unconfigured window slots get no register and read as reserved
  generate
    for (genvar g = 0; g < NUM_BARS; g++) begin : g_bar
      pcr_io_bar #(
        .BASE_PARAM(window_base_params[g*32 +: 32])
      ) u_bar (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .wr_in(req_in.wr && hits(req_in, bar_ofs(g))), // [R3]
        .be_in(req_in.be),
        .wdata_in(req_in.wdata),
        .value_out(bar_value[g])
      );
    end
  endgenerate

  // byte writes into the writable registers; everything else is dropped
  always_comb begin
    state_next = state_reg;
    // cache line length, lane 0 of its dword
    if (wr_hit(req_in, `PCR_OFS_CACHE_LINE)) begin
      state_next.cache_line = wr_byte(req_in, `PCR_OFS_CACHE_LINE); // [R5]
    end
    // latency count, lane 1, only when built writable
    if (latency_writable_param && wr_hit(req_in, `PCR_OFS_LATENCY)) begin
      state_next.latency = wr_byte(req_in, `PCR_OFS_LATENCY); // [R7]
    end
    // interrupt routing line, lane 0 of the interrupt dword
    if (wr_hit(req_in, `PCR_OFS_INT_LINE)) begin
      state_next.int_line = wr_byte(req_in, `PCR_OFS_INT_LINE); // [R15]
    end
  end

  // register flops, cleared by PCI reset
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg.cache_line <= `PCR_RST_CACHE_LINE; // [R5]
      state_reg.latency <= `PCR_RST_LATENCY; // [R7]
      state_reg.int_line <= `PCR_RST_INT_LINE;
    end else begin
      state_reg <= state_next;
    end
  end

  // read selection; unlisted dwords and unused lanes read zero
  always_comb begin
    read_data = 32'h0000_0000; // [R17]
    if (hits(req_in, `PCR_OFS_CACHE_LINE)) begin
      // cache line length and latency count share one dword
      read_data = at_lane(state_reg.cache_line, `PCR_OFS_CACHE_LINE)
                | at_lane(state_reg.latency, `PCR_OFS_LATENCY); // [R5] [R7]
    end else if (hits(req_in, `PCR_OFS_CARD_INFO)) begin
      // build value, no storage behind it
      read_data = card_info_ptr_param; // [R8] [R19]
    end else if (hits(req_in, `PCR_OFS_SUBSYS)) begin
      // maker code low half, product code high half
      read_data = {subsys_product_param, subsys_maker_param}; // [R9] [R10] [R11]
    end else if (hits(req_in, `PCR_OFS_CAP_PTR)) begin
      // pointer only shown when the capability list is enabled
      read_data = capability_enable_param ?
                  at_lane(capability_ptr_param, `PCR_OFS_CAP_PTR) : 32'h0000_0000; // [R12]
    end else if (hits(req_in, `PCR_OFS_INT_LINE)) begin
      // line, pin, max latency and min grant in one dword
      read_data = at_lane(state_reg.int_line, `PCR_OFS_INT_LINE)
                | at_lane(interrupt_enable_param ? `PCR_INT_PIN_A : `PCR_INT_PIN_NONE,
                          `PCR_OFS_INT_PIN) // [R16]
                | at_lane(max_latency_param, `PCR_OFS_MAX_LAT) // [R14]
                | at_lane(min_grant_param, `PCR_OFS_MIN_GNT); // [R13]
    end else begin
      // io windows; slots beyond NUM_BARS stay reserved
      for (int i = 0; i < NUM_BARS; i++) begin
        if (hits(req_in, bar_ofs(i))) begin
          read_data = bar_value[i];
        end
      end
    end
  end

  // every access completes, reserved ones included
  // no retry or abort path exists in this block
  assign taken = req_in.rd || req_in.wr; // [R17]

  // answer stage
  pcr_read_reg u_rsp (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .ack_in(taken),
    .data_in(read_data),
    .rsp_out(rsp_out)
  );

  // local-side outputs straight from flops, except the bus width flag, which is a constant
  assign cache_line_out = state_reg.cache_line; // [R6]
  assign latency_count_out = state_reg.latency;
  assign interrupt_line_out = state_reg.int_line;
  assign local_wide_bus_out = (LOCAL_BUS_WIDTH == WIDE_BUS); // [R18]

  // helper: an access to a reserved dword
  // only the assertions and covers read it
  logic rsvd_hit;
  always_comb begin
    rsvd_hit = !(hits(req_in, `PCR_OFS_CACHE_LINE) || hits(req_in, `PCR_OFS_CARD_INFO)
              || hits(req_in, `PCR_OFS_SUBSYS) || hits(req_in, `PCR_OFS_CAP_PTR)
              || hits(req_in, `PCR_OFS_INT_LINE));
    for (int i = 0; i < NUM_BARS; i++) begin
      if (hits(req_in, bar_ofs(i))) begin
        rsvd_hit = 1'b0;
      end
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  a_cache_write: assert property (wr_hit(req_in, `PCR_OFS_CACHE_LINE)
      |=> cache_line_out == $past(req_in.wdata[7:0])) // [R5]
    else $error("cache line length not written");
  a_cache_readback: assert property (req_in.rd && hits(req_in, `PCR_OFS_CACHE_LINE)
      |=> rsp_out.ack && rsp_out.rdata[7:0] == $past(cache_line_out)) // [R6]
    else $error("cache line read differs from local output");
  a_latency_mode: assert property (wr_hit(req_in, `PCR_OFS_LATENCY)
      |=> latency_count_out == (latency_writable_param ? $past(req_in.wdata[15:8])
                                                       : $past(latency_count_out))) // [R7]
    else $error("latency count write handling wrong");
  // a write to the pointer followed by a read must not move it
  a_card_info_read: assert property (req_in.wr && hits(req_in, `PCR_OFS_CARD_INFO)
      ##1 req_in.rd && hits(req_in, `PCR_OFS_CARD_INFO)
      |=> rsp_out.rdata == card_info_ptr_param) // [R8] [R19]
    else $error("card info pointer changed");
  a_subsys_read: assert property (req_in.rd && hits(req_in, `PCR_OFS_SUBSYS)
      |=> rsp_out.rdata == {subsys_product_param, subsys_maker_param}) // [R9] [R10] [R11]
    else $error("subsystem codes wrong");
  a_cap_ptr_read: assert property (req_in.rd && hits(req_in, `PCR_OFS_CAP_PTR)
      |=> rsp_out.rdata[7:0] == (capability_enable_param ? capability_ptr_param : 8'h00)) // [R12]
    else $error("capability pointer wrong");
  a_int_word_read: assert property (req_in.rd && hits(req_in, `PCR_OFS_INT_LINE)
      |=> rsp_out.rdata[31:8] == {min_grant_param, max_latency_param,
          (interrupt_enable_param ? `PCR_INT_PIN_A : `PCR_INT_PIN_NONE)}) // [R13] [R14] [R16]
    else $error("grant, latency or pin field wrong");
  a_int_line_store: assert property (wr_hit(req_in, `PCR_OFS_INT_LINE) ##1 !req_in.wr
      |=> interrupt_line_out == $past(req_in.wdata[7:0], 2)) // [R15]
    else $error("interrupt line not held");
  a_rsvd_read_zero: assert property (req_in.rd && rsvd_hit |=> rsp_out.ack && rsp_out.rdata == '0) // [R17]
    else $error("reserved location read nonzero");

  // answer one cycle after every access and never otherwise
  a_access_ack: assert property (taken |=> rsp_out.ack) // [R17]
    else $error("access not answered next cycle");
  a_idle_no_ack: assert property (!taken |=> !rsp_out.ack) // [R17]
    else $error("answer given without an access");
  a_bus_width: assert property (local_wide_bus_out == (PCI_BUS_WIDTH == WIDE_BUS)) // [R18]
    else $error("local bus width differs from pci width");

  // writable registers keep their value unless their own lane is written
  a_cache_hold: assert property (!wr_hit(req_in, `PCR_OFS_CACHE_LINE)
      |=> $stable(cache_line_out)) // [R5]
    else $error("cache line length changed without a write");
  a_latency_hold: assert property (!(latency_writable_param && wr_hit(req_in, `PCR_OFS_LATENCY))
      |=> $stable(latency_count_out)) // [R7]
    else $error("latency count changed without a write");
  a_int_line_hold: assert property (!wr_hit(req_in, `PCR_OFS_INT_LINE)
      |=> $stable(interrupt_line_out)) // [R15]
    else $error("interrupt line changed without a write");

  // reserved writes leave every writable register untouched
  a_rsvd_write_drop: assert property (req_in.wr && rsvd_hit
      |=> $stable(cache_line_out) && $stable(latency_count_out)
          && $stable(interrupt_line_out)) // [R17]
    else $error("reserved write reached a register");

  // latency count sits in lane 1 of the cache line dword, upper lanes zero
  a_latency_readback: assert property (req_in.rd && hits(req_in, `PCR_OFS_CACHE_LINE)
      |=> rsp_out.rdata[31:8] == {16'h0000, $past(latency_count_out)}) // [R7] [R17]
    else $error("latency count or unused lanes read wrong");

  // a write answers with the word as it stood before the write
  a_write_old_word: assert property (req_in.wr && hits(req_in, `PCR_OFS_CACHE_LINE)
      |=> rsp_out.rdata[7:0] == $past(cache_line_out)) // [R5]
    else $error("write answer does not carry the old word");

  // capability dword shows nothing above its pointer byte
  a_cap_upper_zero: assert property (req_in.rd && hits(req_in, `PCR_OFS_CAP_PTR)
      |=> rsp_out.rdata[31:8] == 24'h00_0000) // [R12] [R17]
    else $error("capability dword upper lanes nonzero");

  // first io window reads back what it holds, attribute bits included
  a_bar_readback: assert property (req_in.rd && hits(req_in, bar_ofs(0))
      |=> rsp_out.rdata == $past(bar_value[0])) // [R1] [R3]
    else $error("io window read differs from its contents");

  // read data stands between answers
  a_rdata_stands: assert property (!taken |=> $stable(rsp_out.rdata)) // [R17]
    else $error("read data moved without an access");

  // main scenarios reached by the bench

  c_cache_write: cover property (wr_hit(req_in, `PCR_OFS_CACHE_LINE) ##1 req_in.rd);
  c_bar_read: cover property (req_in.rd && hits(req_in, bar_ofs(0)));
  c_rsvd_write: cover property (req_in.wr && rsvd_hit);
  c_int_word: cover property (req_in.rd && hits(req_in, `PCR_OFS_INT_LINE));
  c_card_rewrite: cover property (req_in.wr && hits(req_in, `PCR_OFS_CARD_INFO) ##1 req_in.rd);

endmodule // pcr_header_regs

`default_nettype wire

// ===== bench/pcr_host_model.sv
// host bridge model issuing configuration reads and writes
`timescale 1ns/10ps
`default_nettype none

module pcr_host_model (
  input wire logic clock_in,
  output pcr_pkg::pcr_req_t req_out
);
  import pcr_pkg::*;

  // bus starts idle with no strobe
  initial begin
    req_out = '0;
  end

  // release the request: strobes low, qualifiers turned over on each call, so every second idle cycle repeats the stale values
  task automatic idle();
    pcr_req_t r;
    r = ~req_out;
    r.wr = 1'b0;
    r.rd = 1'b0;
    @(posedge clock_in);
    req_out <= r;
  endtask

  // one access taken at an edge after gap idle cycles; rd and wr never together
  task automatic issue(input logic wr, input logic [5:0] dword, input logic [3:0] be,
                       input logic [31:0] wdata, input int gap);
    pcr_req_t r;
    for (int i = 0; i < gap; i++) begin
      idle();
    end
    r.wr = wr;
    r.rd = ~wr;
    r.dword = dword;
    r.be = be;
    r.wdata = wdata;
    @(posedge clock_in);
    req_out <= r;
  endtask
endmodule // pcr_host_model

`default_nettype wire

// ===== bench/pcr_header_regs_tb_top.sv
// self-checking bench of the configuration header registers
`timescale 1ns/10ps
`default_nettype none

module pcr_header_regs_tb_top;
  import pcr_pkg::*;

  localparam logic [31:0] BAR0_P = 32'hFFFF_FF01; // io window, space bit set
  localparam logic [31:0] BAR1_P = 32'hFFFF_FFC2; // space bit clear, bit 1 set in build
  localparam logic [31:0] CARD_P = 32'h1234_5678;
  localparam logic [15:0] MAKER_P = 16'hA5C3; // arbitrary value
  localparam logic [15:0] PROD_P = 16'h3C5A; // arbitrary value
  localparam logic [7:0] CAP_P = 8'h48;
  localparam logic [7:0] MING_P = 8'h11;
  localparam logic [7:0] MAXL_P = 8'h22;

  logic clock_in; // pci clock
  logic rst_in; // async reset
  pcr_req_t req; // host request
  pcr_rsp_t rsp; // device answer
  logic [7:0] cache_line_out;
  logic [7:0] latency_count_out;
  logic [7:0] interrupt_line_out;
  logic local_wide_bus_out;
  logic [32:0] exp_q[$]; // bit 32 set when read data is compared
  logic [32:0] e; // note taken off the queue
  logic [31:0] seed; // lfsr state
  logic [31:0] v; // expected window value
  logic [7:0] cl; // cache line length last written
  int miscompares;
  int check_count;

  pcr_header_regs #(
    .NUM_BARS(2),
    .window_base_params({{4{32'hFFFF_FF01}}, BAR1_P, BAR0_P}),
    .card_info_ptr_param(CARD_P),
    .subsys_maker_param(MAKER_P),
    .subsys_product_param(PROD_P),
    .capability_enable_param(1'b1),
    .capability_ptr_param(CAP_P),
    .min_grant_param(MING_P),
    .max_latency_param(MAXL_P),
    .interrupt_enable_param(1'b1),
    .latency_writable_param(1'b0),
    .PCI_BUS_WIDTH(32)
  ) dut_u (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .req_in(req),
    .rsp_out(rsp),
    .cache_line_out(cache_line_out),
    .latency_count_out(latency_count_out),
    .interrupt_line_out(interrupt_line_out),
    .local_wide_bus_out(local_wide_bus_out)
  );

  pcr_host_model host_u (
    .clock_in(clock_in),
    .req_out(req)
  );

  // clock generator, 100 ns period
  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end

  // next pseudo-random word
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // verdict and end of run
  task automatic wrap_up();
    if (miscompares == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // word comparison
  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask

  // byte output comparison
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask

  // read with its expected word noted
  task automatic rd(input logic [5:0] dw, input logic [31:0] exp, input int gap);
    exp_q.push_back({1'b1, exp});
    host_u.issue(1'b0, dw, 4'hF, seed, gap);
  endtask

  // write; its answer is counted but data not compared
  task automatic wr(input logic [5:0] dw, input logic [3:0] be, input logic [31:0] d,
                    input int gap);
    exp_q.push_back({1'b0, 32'h0000_0000});
    host_u.issue(1'b1, dw, be, d, gap);
  endtask

  // let all answers arrive, bounded
  task automatic drain();
    host_u.idle();
    for (int i = 0; i < 40 && exp_q.size() != 0; i++) begin
      @(negedge clock_in);
    end
    if (exp_q.size() != 0) begin
      miscompares++;
      wrap_up();
    end
  endtask

  // answer watcher: every ack takes the oldest note
  always @(negedge clock_in) begin
    if (rsp.ack === 1'b1) begin
      if (exp_q.size() == 0) begin
        $display("[ERR] t=%0t got=%h exp=%h", $time, rsp.rdata, 32'h0000_0000);
        miscompares++;
      end else begin
        e = exp_q.pop_front();
        if (e[32]) begin
          cmp32(rsp.rdata, e[31:0]);
        end
      end
    end
  end

  // watchdog against a hang
  initial begin
    repeat (5000) @(posedge clock_in);
    miscompares++;
    wrap_up();
  end

  // main sequence
  initial begin
    rst_in = 1'b1;
    seed = 32'h5069;
    miscompares = 0;
    check_count = 0;
    repeat (12) @(posedge clock_in);
    rst_in <= 1'b0;
    rd(6'h03, 32'h0000_0000, 0);
    seed = lfsr_next(seed);
    wr(6'h03, 4'hF, seed, 0);
    cl = seed[7:0];
    rd(6'h03, {24'h000000, seed[7:0]}, 0);
    for (int i = 0; i < 2; i++) begin
      v = (i == 0) ? BAR0_P : BAR1_P;
      rd(6'h04 + 6'(i), {v[31:2], 1'b0, v[0]}, 0);
      seed = lfsr_next(seed);
      wr(6'h04 + 6'(i), 4'hF, seed, 0);
      v = {seed[31:2], 1'b0, v[0]};
      rd(6'h04 + 6'(i), v, 2);
      seed = lfsr_next(seed);
      wr(6'h04 + 6'(i), 4'h2, ~seed, 0);
      rd(6'h04 + 6'(i), {v[31:16], ~seed[15:8], v[7:0]}, 0);
    end
    wr(6'h0A, 4'hF, 32'hFFFF_FFFF, 0);
    rd(6'h0A, CARD_P, 0);
    wr(6'h0B, 4'hF, 32'hFFFF_FFFF, 0);
    wr(6'h0D, 4'hF, 32'hFFFF_FFFF, 0);
    wr(6'h06, 4'hF, 32'hFFFF_FFFF, 0);
    wr(6'h20, 4'hF, 32'hFFFF_FFFF, 1);
    rd(6'h0A, CARD_P, 0);
    rd(6'h0B, {PROD_P, MAKER_P}, 0);
    rd(6'h0D, {24'h000000, CAP_P}, 0);
    rd(6'h06, 32'h0000_0000, 0);
    rd(6'h20, 32'h0000_0000, 0);
    seed = lfsr_next(seed);
    wr(6'h0F, 4'hF, seed, 3);
    rd(6'h0F, {MING_P, MAXL_P, 8'h01, seed[7:0]}, 0);
    drain();
    cmp8(interrupt_line_out, seed[7:0]);
    cmp8(latency_count_out, 8'h00);
    cmp8({7'h00, local_wide_bus_out}, 8'h00);
    cmp8(cache_line_out, cl);
    rd(6'h03, {24'h000000, cl}, 0);
    drain();
    rst_in <= 1'b1;
    @(posedge clock_in);
    rst_in <= 1'b0;
    cmp8(cache_line_out, 8'h00);
    rd(6'h04, BAR0_P, 0);
    drain();
    wrap_up();
  end
endmodule // pcr_header_regs_tb_top

`default_nettype wire
